// File: rtl/i2chst_master.sv
// Two-wire bus master that reads and writes the register port of the device
`include "i2chst_params.svh"
`default_nettype none

module i2chst_master
   import i2chst_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Command request
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_ptr,
   input wire logic [7:0] cmd_len,
   // Write data stream
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   // Read data stream
   output logic rd_valid,
   output logic [7:0] rd_data,
   // Status
   output logic busy,
   output logic done,
   output logic nack_err,
   // Serial clock pin
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   // Serial data pin
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   localparam logic [7:0] QTR_LAST = 8'(`I2CHST_QTR_CYC - 1);

   i2chst_state_e state;
   i2chst_phase_t phase;
   logic [7:0] qcnt;
   logic [3:0] bcnt;
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   logic [7:0] ptr;
   logic [7:0] remain;
   logic is_read;
   logic ack_n;
   logic scl_s;
   logic sda_s;
   logic scl_low;
   logic sda_low;
   logic next_scl_low;
   logic next_sda_low;
   logic stall;
   logic tick;
   logic byte_state;
   logic tx_state;
   logic phase_end;
   logic byte_end;
   logic bus_idle;

   // Bring both pins into the system clock domain
   i2chst_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in({scl_i, sda_i}),
      .sync_out({scl_s, sda_s})
   );

   // Open-drain pins: drive low or let the pull-up win
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_low;
   assign sda_oe = sda_low;

   // User-side handshakes and status
   assign bus_idle = scl_s & sda_s;
   assign cmd_ready = (state == I2CHST_IDLE) & bus_idle;
   assign wr_ready = (state == I2CHST_WWAIT);
   assign busy = (state != I2CHST_IDLE);

   // Byte-carrying states run nine bit slots
   assign byte_state = (state == I2CHST_ADDR) | (state == I2CHST_PTR) |
                       (state == I2CHST_RADDR) | (state == I2CHST_WDATA) |
                       (state == I2CHST_RDATA);
   assign tx_state = byte_state & (state != I2CHST_RDATA);

   // Hold the quarter timer while a released SCL is still held low
   assign stall = !scl_low & !scl_s;
   assign tick = (qcnt == QTR_LAST) & !stall;
   assign phase_end = tick & (phase == 2'd3);
   assign byte_end = phase_end & (bcnt == `I2CHST_ACK_SLOT);

   // Quarter period timer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         qcnt <= `I2CHST_RST_QCNT;
      end else if (state == I2CHST_IDLE || state == I2CHST_WWAIT || tick) begin
         qcnt <= `I2CHST_RST_QCNT;
      end else if (!stall) begin
         qcnt <= qcnt + 8'h01;
      end
   end

   // Quarter phase within one bit or framing condition
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase <= 2'd0;
      end else if (state == I2CHST_IDLE || state == I2CHST_WWAIT) begin
         phase <= 2'd0;
      end else if (tick) begin
         phase <= phase + 2'd1;
      end
   end

   // Pin drive for each state and quarter phase
   always_comb begin
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      case (state)
         I2CHST_IDLE: next_scl_low = 1'b0; // Both lines left to the pull-ups
         I2CHST_START: begin
            // SDA falls in phase 1 with SCL high
            next_scl_low = (phase == 2'd3);
            next_sda_low = (phase != 2'd0);
         end
         I2CHST_RSTART: begin
            // Release SDA under low SCL, then fall with SCL high
            next_scl_low = (phase == 2'd0) | (phase == 2'd3);
            next_sda_low = (phase[1] == 1'b1);
         end
         I2CHST_STOP: begin
            // SDA rises in phase 2 with SCL high
            next_scl_low = (phase == 2'd0);
            next_sda_low = (phase[1] == 1'b0);
         end
         I2CHST_WWAIT: begin
            // Park with SCL low and the data line released
            next_scl_low = 1'b1;
            next_sda_low = 1'b0;
         end
         default: begin
            // Bit slot: SCL high in phases 1 and 2 only
            next_scl_low = (phase == 2'd0) | (phase == 2'd3);
            if (bcnt == `I2CHST_ACK_SLOT) begin
               // Release for the slave ack, or ack or nack a read byte
               if (tx_state) begin
                  next_sda_low = 1'b0;
               end else begin
                  next_sda_low = (remain != 8'h01);
               end
            end else if (tx_state) begin
               next_sda_low = !tx_shift[7];
            end else begin
               next_sda_low = 1'b0;
            end
         end
      endcase
   end

   // Registered pin drivers; in bit slots SDA moves only at the phase 0 boundary
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else begin
         scl_low <= next_scl_low;
         sda_low <= next_sda_low;
      end
   end

   // Bit slot counter, nine slots per byte
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bcnt <= 4'h0;
      end else if (!byte_state) begin
         bcnt <= 4'h0;
      end else if (byte_end) begin
         bcnt <= 4'h0;
      end else if (phase_end) begin
         bcnt <= bcnt + 4'h1;
      end
   end

   // Sample SDA at the end of the SCL high period
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rx_shift <= `I2CHST_RST_BYTE;
         ack_n <= 1'b1;
      end else if (byte_state && tick && phase == 2'd2) begin
         if (bcnt == `I2CHST_ACK_SLOT) begin
            ack_n <= sda_s;
         end else begin
            rx_shift <= {rx_shift[6:0], sda_s};
         end
      end
   end

   // Transmit shift register, loaded per byte, MSB out first
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_shift <= `I2CHST_RST_BYTE;
      end else if (state == I2CHST_START && phase_end) begin
         tx_shift <= {`I2CHST_SLAVE_ADDR, `I2CHST_DIR_WRITE};
      end else if (state == I2CHST_ADDR && byte_end) begin
         tx_shift <= ptr;
      end else if (state == I2CHST_RSTART && phase_end) begin
         tx_shift <= {`I2CHST_SLAVE_ADDR, `I2CHST_DIR_READ};
      end else if (state == I2CHST_WWAIT && wr_valid) begin
         tx_shift <= wr_data;
      end else if (tx_state && phase_end && bcnt < `I2CHST_ACK_SLOT) begin
         tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   // Command capture and remaining byte count
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ptr <= `I2CHST_RST_BYTE;
         remain <= `I2CHST_RST_BYTE;
         is_read <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         ptr <= cmd_ptr;
         remain <= cmd_len;
         is_read <= cmd_read;
      end else if ((state == I2CHST_WDATA || state == I2CHST_RDATA) && byte_end) begin
         // The device steps its own pointer; track the count here
         remain <= remain - 8'h01;
      end
   end

   // Transaction sequencer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= I2CHST_IDLE;
      end else begin
         case (state)
            I2CHST_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  state <= I2CHST_START;
               end
            end
            I2CHST_START: begin
               if (phase_end) begin
                  state <= I2CHST_ADDR;
               end
            end
            I2CHST_ADDR: begin
               if (byte_end) begin
                  state <= ack_n ? I2CHST_STOP : I2CHST_PTR;
               end
            end
            I2CHST_PTR: begin
               if (byte_end) begin
                  if (ack_n || remain == 8'h00) begin
                     state <= I2CHST_STOP;
                  end else if (is_read) begin
                     state <= I2CHST_RSTART;
                  end else begin
                     state <= I2CHST_WWAIT;
                  end
               end
            end
            I2CHST_RSTART: begin
               if (phase_end) begin
                  state <= I2CHST_RADDR;
               end
            end
            I2CHST_RADDR: begin
               if (byte_end) begin
                  state <= ack_n ? I2CHST_STOP : I2CHST_RDATA;
               end
            end
            I2CHST_WWAIT: begin
               if (wr_valid) begin
                  state <= I2CHST_WDATA;
               end
            end
            I2CHST_WDATA: begin
               if (byte_end) begin
                  if (ack_n || remain == 8'h01) begin
                     state <= I2CHST_STOP;
                  end else begin
                     state <= I2CHST_WWAIT;
                  end
               end
            end
            I2CHST_RDATA: begin
               if (byte_end) begin
                  if (remain == 8'h01) begin
                     state <= I2CHST_STOP;
                  end else begin
                     state <= I2CHST_RDATA;
                  end
               end
            end
            I2CHST_STOP: begin
               if (phase_end) begin
                  state <= I2CHST_IDLE;
               end
            end
            default: begin
               state <= I2CHST_IDLE;
            end
         endcase
      end
   end

   // Read data strobe, one pulse per received byte
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_valid <= 1'b0;
         rd_data <= `I2CHST_RST_BYTE;
      end else begin
         rd_valid <= (state == I2CHST_RDATA) && byte_end;
         if (state == I2CHST_RDATA && byte_end) begin
            rd_data <= rx_shift;
         end
      end
   end

   // Completion pulse at the end of the stop condition
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         done <= 1'b0;
      end else begin
         done <= (state == I2CHST_STOP) && phase_end;
      end
   end

   // Sticky refusal flag, cleared when the next command is taken
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         nack_err <= 1'b0;
      end else if (tx_state && byte_end && ack_n) begin
         nack_err <= 1'b1;
      end else if (cmd_valid && cmd_ready) begin
         nack_err <= 1'b0;
      end
   end

endmodule // i2chst_master

`default_nettype wire

// File: rtl/i2chst_params.svh
// Constants for the two-wire register port master
`ifndef I2CHST_PARAMS_SVH
`define I2CHST_PARAMS_SVH

// Fixed bus address of the register port
`define I2CHST_SLAVE_ADDR 7'h7E
// Direction bit values after the address
`define I2CHST_DIR_READ 1'b1
`define I2CHST_DIR_WRITE 1'b0
// Bits per byte and index of the acknowledge slot
`define I2CHST_BYTE_BITS 8
`define I2CHST_ACK_SLOT 4'h8
// System clock period and quarter of a serial clock period, in ns
`define I2CHST_SYSCLK_NS 100
`define I2CHST_QTR_NS 2500
// Quarter period in system clocks, rounded up
`define I2CHST_QTR_CYC ((`I2CHST_QTR_NS + `I2CHST_SYSCLK_NS - 1) / `I2CHST_SYSCLK_NS)
// Reset values
`define I2CHST_RST_BYTE 8'h00
`define I2CHST_RST_QCNT 8'h00

`endif

// File: rtl/i2chst_pkg.sv
// Types shared by the two-wire register port master
`default_nettype none

package i2chst_pkg;

   // Transaction sequencer states
   typedef enum logic [3:0] {
      I2CHST_IDLE,
      I2CHST_START,
      I2CHST_ADDR,
      I2CHST_PTR,
      I2CHST_RSTART,
      I2CHST_RADDR,
      I2CHST_WWAIT,
      I2CHST_WDATA,
      I2CHST_RDATA,
      I2CHST_STOP
   } i2chst_state_e;

   // Quarter phase of one serial clock period
   typedef logic [1:0] i2chst_phase_t;

endpackage

`default_nettype wire

// File: rtl/i2chst_sync.sv
// Two-flop synchroniser for the bus pin inputs
`default_nettype none

module i2chst_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Asynchronous inputs
   input wire logic [1:0] async_in,
   // Synchronised outputs
   output logic [1:0] sync_out
);

   genvar i;

   // One pair of flops per pin; lines idle high
   generate
      for (i = 0; i < 2; i++) begin : g_bit
         logic meta;
         logic stable;
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               meta <= 1'b1;
               stable <= 1'b1;
            end else begin
               meta <= async_in[i];
               stable <= meta;
            end
         end
         assign sync_out[i] = stable;
      end
   endgenerate

endmodule // i2chst_sync

`default_nettype wire

// File: tb/i2chst_chk.sv
// Bound checks on the two-wire register port master
`default_nettype none
module i2chst_chk
   import i2chst_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Command and status
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic wr_ready,
   input wire logic rd_valid,
   input wire logic busy,
   input wire logic done,
   input wire logic nack_err,
   // Bus pins
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Start condition: data pulled while the clock is released
   sequence start_s;
      sda_oe && !scl_oe;
   endsequence
   // Completion pulse seen back in idle
   sequence done_s;
      !busy ##1 !done;
   endsequence
   accept_a: assert property (cmd_valid && cmd_ready |=> busy ##[1:60] start_s)
      else $error("no start after accept");
   restart_a: assert property ($rose(sda_oe) && scl_i |-> ##[1:60] $rose(scl_oe))
      else $error("clock not pulled after start");
   stop_done_a: assert property ($fell(sda_oe) && scl_i |-> ##[1:60] done)
      else $error("no completion after stop");
   done_pulse_a: assert property (done |-> done_s)
      else $error("completion pulse wrong");
   idle_free_a: assert property (!busy && !$past(busy) |-> !scl_oe && !sda_oe)
      else $error("lines pulled while idle");
   busy_ready_a: assert property (busy |-> !cmd_ready)
      else $error("ready while busy");
   rd_pulse_a: assert property (rd_valid |-> busy ##1 !rd_valid)
      else $error("read byte pulse wrong");
   nack_stop_a: assert property ($rose(nack_err) |-> ##[1:250] done)
      else $error("no stop after refusal");
   wr_hold_a: assert property (wr_ready |-> busy && scl_oe)
      else $error("clock not held low while waiting");
   open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("pin driven high");
endmodule // i2chst_chk

bind i2chst_master i2chst_chk chk_u (
   .sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .wr_ready(wr_ready), .rd_valid(rd_valid), .busy(busy), .done(done),
   .nack_err(nack_err), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

// File: tb/i2chst_dev_model.sv
// Behavioural register port device on the two-wire bus
`default_nettype none
module i2chst_dev_model (
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe,
   // Behaviour controls
   input wire logic [6:0] dev_addr,
   input wire logic [15:0] stretch
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] regs [256]; // Storage behind the access path
   logic [7:0] ptr;
   logic [7:0] sh;
   int bitn;
   int mode; // 0 idle, 1 address, 2 pointer, 3 write, 4 read
   // Power-up state
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      mode = 0;
      bitn = 0;
      foreach (regs[i]) regs[i] = 8'h00;
   end
   // Start or repeated start restarts matching
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         mode = 1;
         bitn = -1;
         sda_oe = 1'b0;
      end
   end
   // Stop, or any rise while the clock is high, abandons the transfer
   always @(posedge sda) begin
      if (scl === 1'b1) mode = 0;
   end
   // Sample while the clock is high, MSB first
   always @(posedge scl) begin
      if (mode == 4 && bitn == 8 && sda !== 1'b0) mode = 0; // Last byte refused
      else if (bitn < 8) sh = {sh[6:0], sda};
   end
   // Drive on the falling clock edge
   always @(negedge scl) begin
      if (mode != 0 && bitn == 7 && mode != 4) begin
         bitn = 8;
         if (mode == 1 && sh[7:1] != dev_addr) mode = 0;
         else sda_oe = 1'b1; // Ack held low through the pulse
         if (mode == 2) ptr = sh;
         if (mode == 3) regs[ptr] = sh;
         if (mode == 3) ptr = ptr + 8'h01;
      end else if (mode != 0 && bitn == 7) begin
         bitn = 8;
         sda_oe = 1'b0; // Transmitter releases for the ack slot
      end else if (mode != 0 && bitn == 8) begin
         bitn = 0;
         sda_oe = 1'b0;
         if (mode == 4) ptr = ptr + 8'h01;
         if (mode == 1) mode = sh[0] ? 4 : 2;
         else if (mode == 2) mode = 3;
         if (mode == 4) sda_oe = !regs[ptr][7];
      end else if (mode != 0) begin
         bitn = bitn + 1;
         if (mode == 4 && bitn > 0) sda_oe = !regs[ptr][7 - bitn];
      end
   end
   // Slow answer: hold the clock low after each fall
   always @(negedge scl) begin
      if (stretch != 16'h0000) begin
         scl_oe = 1'b1;
         #(stretch);
         scl_oe = 1'b0;
      end
   end
endmodule // i2chst_dev_model
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the two-wire register port master
`include "i2chst_params.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rstn, cmd_valid, cmd_read, wr_valid;
   logic [7:0] cmd_ptr, cmd_len, wr_data, rd_data;
   logic cmd_ready, wr_ready, rd_valid, busy, done, nack_err;
   logic scl_o, scl_oe, sda_o, sda_oe, dev_scl_oe, dev_sda_oe;
   logic [6:0] dev_addr;
   logic [15:0] stretch;
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   int miscompares = 0;
   int tests_run = 0;
   // Pulled-up open-drain lines
   wire logic scl = !(scl_oe || dev_scl_oe);
   wire logic sda = !(sda_oe || dev_sda_oe);
   i2chst_master dut_u (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .busy(busy), .done(done), .nack_err(nack_err), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   i2chst_dev_model model_u (.scl(scl), .sda(sda), .scl_oe(dev_scl_oe),
      .sda_oe(dev_sda_oe), .dev_addr(dev_addr), .stretch(stretch));
   // Compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One transaction: command, write stream, read stream, completion
   task automatic run(input logic rd, input logic [7:0] ptr, input logic [7:0] len,
      input int stall);
      int n;
      int w;
      rq.delete();
      w = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_read <= rd;
      cmd_ptr <= ptr;
      cmd_len <= len;
      @(posedge sys_clk);
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge sys_clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 30000 && done !== 1'b1; n++) begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1) rq.push_back(rd_data);
         if (wr_ready === 1'b1 && wr_valid) begin
            void'(wq.pop_front());
            wr_valid <= 1'b0;
            w = 0;
         end else if (wr_ready === 1'b1 && ++w > stall) begin
            wr_valid <= 1'b1;
            wr_data <= wq[0];
         end
      end
      check({7'h00, done}, 8'h01);
      check({7'h00, busy}, 8'h00);
   endtask
   // Three bytes to consecutive registers, with the writer stalling
   task automatic t_write;
      wq = {8'hA5, 8'h3C, 8'h81};
      run(1'b0, 8'h10, 8'h03, 40);
      check({7'h00, nack_err}, 8'h00);
      check(model_u.regs[8'h10], 8'hA5);
      check(model_u.regs[8'h11], 8'h3C);
      check(model_u.regs[8'h12], 8'h81);
      // Pointer-only write: no data bytes, the stop follows the pointer
      run(1'b0, 8'h05, 8'h00, 0);
      check(model_u.ptr, 8'h05);
      check(model_u.regs[8'h05], 8'h00);
      $display("write test done");
   endtask
   // Slow burst read, then a prompt single read at a new pointer
   task automatic t_read;
      stretch = 16'd8000;
      run(1'b1, 8'h10, 8'h03, 0);
      stretch = 16'h0000;
      check(8'(rq.size()), 8'h03);
      check(rq[0], 8'hA5);
      check(rq[1], 8'h3C);
      check(rq[2], 8'h81);
      check(model_u.ptr, 8'h12);
      run(1'b1, 8'h11, 8'h01, 0);
      check(rq[0], 8'h3C);
      check(model_u.ptr, 8'h11);
      check({7'h00, nack_err}, 8'h00);
      $display("read test done");
   endtask
   // Device at another address leaves the master unanswered
   task automatic t_nack;
      dev_addr = 7'h3F;
      wq = {8'h55};
      run(1'b0, 8'h20, 8'h01, 0);
      check({7'h00, nack_err}, 8'h01);
      check(model_u.regs[8'h20], 8'h00);
      dev_addr = `I2CHST_SLAVE_ADDR;
      $display("refusal test done");
   endtask
   // Counts and verdict
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // System clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Watchdog, about three times the expected run
   initial begin
      #6000000;
      miscompares++;
      finish_test();
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_ptr = 8'h00;
      cmd_len = 8'h00;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      dev_addr = `I2CHST_SLAVE_ADDR;
      stretch = 16'h0000;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      t_write();
      t_read();
      t_nack();
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
